// File: io_port_and_scan_control.sv
// I/O instruction effects: display latch loads, three 4-bit ports, key scan,
// buzzer and EL pump control. Commands arrive one per cycle from the core;
// pins are split into in/out/enable and resolved outside.
// How it works
// - Working register n lives at data address n+70H.
// - Eight-bit index pointer, nibbles loaded separately.
// - Latch selector 00H to 1FH picks target.
// - Decoded load passes source nibble through decoder.
// - Blanking load outputs all zero for zero.
// - Direct load writes source and accumulator undecoded.
// - Source drives lines A-D, accumulator E-H.
// - Table load copies ROM byte at pointer.
// - Pull-low applies only to input pins.
// - Port C bit 4 swaps pull-low and hold.
// - Port write drives memory nibble onto port.
// - Special write: pins 1-2 data, 3 bit, 4 pulse.
// - Port read loads pins into accumulator and memory.
// - Scan bit 6 picks halt release source.
// - Scan operand sets key lines during scan.
// - Single line, all lines, or all floating.
// - Lower eight or upper four lines driven.
// - Groups of four or adjacent pairs driven.
// - Buzzer tone source by bits 8 to 6.
// - Bits 5-0 enable 1 Hz to 32 Hz envelopes.
// - Divided tones derive from 32768 Hz prescaler; code 7 takes the tone generator.
// - EL pump frequency and duty from operand.
module io_port_and_scan_control
    import io_port_pkg::*;
#(
    parameter int PULSE_LEN = SPECIAL_PULSE_CYCLES
)(
    input  wire logic        mclk,                // 250 MHz instruction clock
    input  wire logic        sys_rst,             // synchronous reset, high
    input  wire logic        cmdValid,            // command strobe
    input  wire cmd_t        cmd,                 // command code
    input  wire logic [6:0]  cmdAddr,             // data memory address
    input  wire logic [3:0]  cmdReg,              // working register selector
    input  wire logic        cmdIndexed,          // use index pointer as source
    input  wire logic [4:0]  cmdLatch,            // display latch selector
    input  wire logic [8:0]  cmdOperand,          // immediate operand
    input  wire logic [7:0]  tableData,           // table ROM word at pointer
    input  wire logic [11:0] portPinIn,           // pin levels C,B,A high to low
    input  wire logic [11:0] segmentDrive,        // normal drive of key lines
    input  wire logic        scanInterval,        // key scan interval active
    input  wire logic        displayActiveLow,    // display polarity
    input  wire logic        toneGeneratorOutput, // frequency generator output
    output logic      [7:0]  indexPointer,        // index pointer, table address
    output logic             latchWrite,          // latch write pulse
    output logic      [4:0]  latchAddr,           // latch written
    output logic      [7:0]  latchData,           // decoder bus lines H..A
    output logic      [3:0]  accumulator,         // accumulator
    output logic      [3:0]  memReadData,         // memory read result
    output logic      [11:0] portPinOut,          // port pin drive values
    output logic      [11:0] portPinOe,           // port pin output enables
    output logic      [11:0] pullLowEn,           // pull-low device on
    output logic      [3:0]  lowLevelHoldEn,      // port C hold device on
    output logic      [11:0] keyLineOut,          // key line drive values
    output logic      [11:0] keyLineOe,           // key line enables
    output logic             haltReleaseByCycle,  // halt release source
    output logic             buzzerOut,           // buzzer pin
    output logic             buzzerOutInverted,   // complementary buzzer pin
    output logic             elPumpPin            // EL pumping pin
);
    localparam int PULSE_W = $clog2(PULSE_LEN + 1);

    if (PULSE_LEN < 1)
        $error("PULSE_LEN must be at least one cycle");

    // Memory content is undefined after reset; software must initialise it
    logic [3:0]         dataMem [MEM_WORDS];
    logic [6:0]         wregAddr;
    logic [6:0]         srcAddr;
    logic [3:0]         srcData;
    logic [3:0]         rxData;
    logic [11:0]        syncA;
    logic [11:0]        syncB;
    logic [11:0]        syncC;
    logic [11:0]        pinStable;
    logic [2:0][3:0]    portDir;
    logic [2:0]         portPull;
    logic [7:0]         scanSel;
    logic [11:0]        scanMask;
    logic [PULSE_W-1:0] pulseCnt;
    logic [1:0]         portIdx;
    logic               isRead;
    logic               isWrite;
    logic               isConfig;
    logic               isLatch;

    tone_if tone ();

    // Hex to seven-segment on lines A..G, H stays dark
    function automatic logic [7:0] segDecode(input logic [3:0] nib, input logic blank);
        logic [7:0] segMap [16];
        segMap = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
                   8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
        return (blank && nib == 4'h0) ? 8'h00 : segMap[nib];
    endfunction

    function automatic logic [1:0] portOf(input cmd_t k);
        unique case (k)
            CMD_PORT_B_CONFIG, CMD_PORT_B_WRITE, CMD_PORT_B_READ: return 2'h1;
            CMD_PORT_C_CONFIG, CMD_PORT_C_WRITE, CMD_PORT_C_READ: return 2'h2;
            default: return 2'h0;
        endcase
    endfunction

    assign wregAddr = WREG_BASE + 7'(cmdReg);
    assign srcAddr  = cmdIndexed ? indexPointer[6:0] : wregAddr;
    assign srcData  = dataMem[srcAddr];
    assign rxData   = dataMem[cmdAddr];

    assign portIdx  = portOf(cmd);
    assign isConfig = cmd inside {[CMD_PORT_A_CONFIG:CMD_PORT_C_CONFIG]};
    assign isWrite  = cmd inside {[CMD_PORT_A_WRITE:CMD_PORT_C_WRITE]};
    assign isRead   = cmd inside {[CMD_PORT_A_READ:CMD_PORT_C_READ]};
    assign isLatch  = cmd inside {[CMD_LATCH_DECODED:CMD_LATCH_TABLE]};

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            syncA     <= '0;
            syncB     <= '0;
            syncC     <= '0;
            pinStable <= '0;
        end
        else
        begin
            syncA <= portPinIn;
            syncB <= syncA;
            syncC <= syncB;
            pinStable <= (syncC & ~(syncB ^ syncC)) | (pinStable & (syncB ^ syncC));
        end
    end

    always_ff @(posedge mclk)
    begin
        if (cmdValid)
        begin
            if (cmd == CMD_MEM_WRITE)
                dataMem[cmdIndexed ? indexPointer[6:0] : cmdAddr] <= cmdOperand[3:0];
            else if (isRead)
                dataMem[cmdAddr] <= pinStable[portIdx*4 +: 4];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            accumulator <= 4'h0;
            memReadData <= 4'h0;
        end
        else if (cmdValid)
        begin
            if (cmd == CMD_ACC_WRITE)
                accumulator <= cmdOperand[3:0];
            else if (isRead)
                accumulator <= pinStable[portIdx*4 +: 4];
            if (cmd == CMD_MEM_READ)
                memReadData <= cmdIndexed ? dataMem[indexPointer[6:0]] : rxData;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            indexPointer <= 8'h00;
        else if (cmdValid && cmd == CMD_INDEX_HIGH_LOAD)
            indexPointer[7:4] <= rxData;
        else if (cmdValid && cmd == CMD_INDEX_LOW_LOAD)
            indexPointer[3:0] <= rxData;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            latchWrite <= 1'b0;
            latchAddr  <= 5'h00;
            latchData  <= 8'h00;
        end
        else
        begin
            latchWrite <= cmdValid && isLatch;
            if (cmdValid && isLatch)
            begin
                latchAddr <= cmdLatch;
                if (cmd == CMD_LATCH_DIRECT)
                    latchData <= {accumulator, srcData};
                else if (cmd == CMD_LATCH_TABLE)
                    latchData <= tableData;
                else
                    latchData <= segDecode(srcData, cmd == CMD_LATCH_DECODED_BLK);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            portDir  <= {3{PORT_CFG_RST[3:0]}};
            portPull <= {3{PORT_CFG_RST[PORT_PULL_BIT]}};
        end
        else if (cmdValid && isConfig)
        begin
            portDir[portIdx]  <= cmdOperand[3:0];
            portPull[portIdx] <= cmdOperand[PORT_PULL_BIT];
        end
    end

    // Pin drivers follow the configuration one cycle later
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            portPinOe      <= '0;
            pullLowEn      <= '0;
            lowLevelHoldEn <= '0;
        end
        else
        begin
            portPinOe <= portDir;
            for (int p = 0; p < 3; p++)
                pullLowEn[p*4 +: 4] <= {4{portPull[p]}} & ~portDir[p];
            lowLevelHoldEn <= {4{~portPull[2]}} & ~portDir[2];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            portPinOut <= '0;
            pulseCnt   <= '0;
        end
        else
        begin
            if (cmdValid && isWrite)
                portPinOut[portIdx*4 +: 4] <= rxData;
            else if (cmdValid && cmd == CMD_PORT_A_WRITE_SPEC)
            begin
                portPinOut[1:0] <= rxData[1:0];
                portPinOut[2]   <= cmdOperand[0];
                portPinOut[3]   <= 1'b1;
                pulseCnt        <= PULSE_W'(PULSE_LEN - 1);
            end
            else if (portPinOut[3] && pulseCnt != '0)
                pulseCnt <= pulseCnt - 1'b1;
            else if (pulseCnt == '0)
                portPinOut[3] <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            scanSel            <= SCAN_RST;
            haltReleaseByCycle <= 1'b0;
        end
        else if (cmdValid && cmd == CMD_KEY_SCAN_SETUP)
        begin
            scanSel            <= cmdOperand[7:0];
            haltReleaseByCycle <= cmdOperand[SCAN_HALT_BIT];
        end
    end

    key_scan_decoder keyDecode (
        .scanSel   (scanSel),
        .driveMask (scanMask)
    );

    // Outside the scan interval every key line carries its segment drive
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            keyLineOut <= '0;
            keyLineOe  <= '0;
        end
        else if (scanInterval)
        begin
            keyLineOut <= {12{~displayActiveLow}};
            keyLineOe  <= scanMask;
        end
        else
        begin
            keyLineOut <= segmentDrive;
            keyLineOe  <= 12'hFFF;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tone.buzzerSel <= BUZZER_RST;
            tone.elSel     <= EL_RST;
        end
        else if (cmdValid && cmd == CMD_BUZZER_SETUP)
            tone.buzzerSel <= cmdOperand;
        else if (cmdValid && cmd == CMD_EL_DRIVER_SETUP)
            tone.elSel <= cmdOperand;
    end

    assign tone.toneGen = toneGeneratorOutput;

    tone_prescaler tones (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tone    (tone.gen)
    );

    assign buzzerOut         = tone.buzzer;
    assign buzzerOutInverted = tone.buzzerN;
    assign elPumpPin         = tone.pump;
endmodule

// File: io_port_pkg.sv
// Shared constants, command codes and operand field layout for the I/O block.
// Assumes one 250 MHz instruction clock and a synchronous active-high reset.
package io_port_pkg;

    localparam int CLK_HZ           = 250_000_000;
    localparam int CLK_MHZ          = 250;
    localparam int PRESCALE_BASE_HZ = 32768;
    // Counter steps at four times the base rate, so phi k sits on bit k+1
    localparam int PRESCALE_STEP_HZ = 4 * PRESCALE_BASE_HZ;
    localparam int PHASE_W          = 28;
    localparam int PHI_W            = 17;

    localparam int SPECIAL_PULSE_NS     = 1000;
    localparam int SPECIAL_PULSE_CYCLES = (SPECIAL_PULSE_NS * CLK_MHZ + 999) / 1000;

    localparam int         MEM_WORDS = 128;
    localparam logic [6:0] WREG_BASE = 7'h70;

    // Operand field positions
    localparam int PORT_PULL_BIT = 4;
    localparam int SCAN_HALT_BIT = 6;
    localparam int SCAN_GROUP_BIT = 7;
    localparam int SCAN_FLOAT_BIT = 5;
    localparam int SCAN_ALL_BIT  = 4;
    localparam int TONE_SEL_LSB  = 6;
    localparam int ENV_W         = 6;
    localparam int ENV_PHI_BASE  = 10;
    localparam int EL_TONE_GENERATOR_OUTPUT_LSB   = 6;
    localparam int EL_DUTY_LSB   = 4;

    // Tone source codes and their prescaler stages
    localparam logic [2:0] TONE_GEN  = 3'h7;
    localparam logic [2:0] TONE_HIGH = 3'h4;
    localparam logic [2:0] TONE_4K   = 3'h3;
    localparam logic [2:0] TONE_2K   = 3'h2;
    localparam logic [2:0] TONE_1K   = 3'h1;
    localparam logic [2:0] TONE_LOW  = 3'h0;
    localparam int PHI_4K = 3;
    localparam int PHI_2K = 4;
    localparam int PHI_1K = 5;

    localparam logic [1:0] DUTY_3_4  = 2'h0;
    localparam logic [1:0] DUTY_HALF = 2'h2;
    localparam logic [1:0] DUTY_FULL = 2'h3;

    // Reset values
    localparam logic [4:0] PORT_CFG_RST = 5'h00;
    localparam logic [7:0] SCAN_RST     = 8'h20;
    localparam logic [8:0] BUZZER_RST   = 9'h000;
    localparam logic [8:0] EL_RST       = 9'h000;

    typedef enum logic [4:0] {
        CMD_MEM_WRITE         = 5'h00,
        CMD_MEM_READ          = 5'h01,
        CMD_ACC_WRITE         = 5'h02,
        CMD_INDEX_HIGH_LOAD   = 5'h03,
        CMD_INDEX_LOW_LOAD    = 5'h04,
        CMD_LATCH_DECODED     = 5'h05,
        CMD_LATCH_DECODED_BLK = 5'h06,
        CMD_LATCH_DIRECT      = 5'h07,
        CMD_LATCH_TABLE       = 5'h08,
        CMD_PORT_A_CONFIG     = 5'h09,
        CMD_PORT_B_CONFIG     = 5'h0A,
        CMD_PORT_C_CONFIG     = 5'h0B,
        CMD_PORT_A_WRITE      = 5'h0C,
        CMD_PORT_B_WRITE      = 5'h0D,
        CMD_PORT_C_WRITE      = 5'h0E,
        CMD_PORT_A_WRITE_SPEC = 5'h0F,
        CMD_PORT_A_READ       = 5'h10,
        CMD_PORT_B_READ       = 5'h11,
        CMD_PORT_C_READ       = 5'h12,
        CMD_KEY_SCAN_SETUP    = 5'h13,
        CMD_BUZZER_SETUP      = 5'h14,
        CMD_EL_DRIVER_SETUP   = 5'h15
    } cmd_t;

endpackage

// File: tone_if.sv
// Bundle between the instruction logic and the tone/pump generator.
// Assumes both ends run on the same instruction clock.
interface tone_if;
    logic [8:0] buzzerSel;
    logic [8:0] elSel;
    logic       toneGen;
    logic       buzzer;
    logic       buzzerN;
    logic       pump;

    modport ctl (output buzzerSel, elSel, toneGen, input buzzer, buzzerN, pump);
    modport gen (input buzzerSel, elSel, toneGen, output buzzer, buzzerN, pump);
endinterface

// File: key_scan_decoder.sv
// Decodes a key-scan operand into the set of key lines driven during a scan.
// Pure combinational; the caller registers the result.
module key_scan_decoder
    import io_port_pkg::*;
(
    input  wire logic [7:0]  scanSel,   // key_scan_setup operand
    output logic      [11:0] driveMask  // 1 = line driven active
);
    always_comb
    begin
        driveMask = 12'h000;
        if (!scanSel[SCAN_GROUP_BIT])
        begin
            if (scanSel[SCAN_FLOAT_BIT])
                driveMask = 12'h000;
            else if (scanSel[SCAN_ALL_BIT])
                driveMask = 12'hFFF;
            else if (scanSel[3:0] < 4'hC)
                driveMask = 12'h001 << scanSel[3:0];
        end
        else if (!scanSel[SCAN_FLOAT_BIT])
            driveMask = scanSel[3] ? 12'hF00 : 12'h0FF;
        else if (!scanSel[SCAN_ALL_BIT])
        begin
            if (scanSel[3:2] != 2'h3)
                driveMask = 12'h00F << {scanSel[3:2], 2'h0};
        end
        else if (scanSel[3:1] <= 3'h5)
            driveMask = 12'h003 << {scanSel[3:1], 1'h0};
    end
endmodule

// File: tone_prescaler.sv
// Base prescaler chain plus buzzer and EL pumping waveform selection.
// Assumes the tone generator input is already on the instruction clock.
module tone_prescaler
    import io_port_pkg::*;
(
    input  wire logic mclk,    // instruction clock
    input  wire logic sys_rst, // synchronous reset
    tone_if.gen       tone     // selections in, waveforms out
);
    logic [PHASE_W-1:0] phase;
    logic [PHI_W:0]     phiCnt;
    logic               tick;
    logic               toneRaw;
    logic               envOn;
    logic               pumpRaw;
    logic [2:0]         pumpStage;

    // Fractional divider keeps the long-run base rate exact
    assign tick = (phase + PHASE_W'(PRESCALE_STEP_HZ)) >= PHASE_W'(CLK_HZ);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            phase <= '0;
        else if (tick)
            phase <= phase + PHASE_W'(PRESCALE_STEP_HZ) - PHASE_W'(CLK_HZ);
        else
            phase <= phase + PHASE_W'(PRESCALE_STEP_HZ);
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            phiCnt <= '0;
        else if (tick)
            phiCnt <= phiCnt + 1'b1;
    end

    always_comb
    begin
        unique case (tone.buzzerSel[TONE_SEL_LSB +: 3])
            TONE_GEN:  toneRaw = tone.toneGen;
            TONE_HIGH: toneRaw = 1'b1;
            TONE_4K:   toneRaw = phiCnt[PHI_4K+1];
            TONE_2K:   toneRaw = phiCnt[PHI_2K+1];
            TONE_1K:   toneRaw = phiCnt[PHI_1K+1];
            default:   toneRaw = 1'b0;
        endcase
        // Envelope stages gate the tone; none enabled leaves it steady
        envOn = ~|tone.buzzerSel[ENV_W-1:0]
              | |(tone.buzzerSel[ENV_W-1:0] & phiCnt[ENV_PHI_BASE+1 +: ENV_W]);
    end

    always_comb
    begin
        pumpStage = tone.elSel[EL_TONE_GENERATOR_OUTPUT_LSB +: 3];
        unique case (tone.elSel[EL_DUTY_LSB +: 2])
            DUTY_3_4:  pumpRaw = phiCnt[pumpStage+1] | phiCnt[pumpStage];
            DUTY_FULL: pumpRaw = 1'b1;
            default:   pumpRaw = phiCnt[pumpStage+1];
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            tone.buzzer  <= 1'b0;
            tone.buzzerN <= 1'b1;
            tone.pump    <= 1'b0;
        end
        else
        begin
            tone.buzzer  <= toneRaw & envOn;
            tone.buzzerN <= ~(toneRaw & envOn);
            tone.pump    <= pumpRaw;
        end
    end
endmodule

// File: io_port_monitor.sv
// Assertion checker on the I/O block's top-level ports.
// Assumes one clock and a synchronous active-high reset.
module io_port_monitor
    import io_port_pkg::*;
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        cmdValid,
    input wire cmd_t        cmd,
    input wire logic [8:0]  cmdOperand,
    input wire logic [4:0]  cmdLatch,
    input wire logic [7:0]  tableData,
    input wire logic [3:0]  accumulator,
    input wire logic        latchWrite,
    input wire logic [4:0]  latchAddr,
    input wire logic [7:0]  latchData,
    input wire logic [7:0]  indexPointer,
    input wire logic [11:0] portPinOut,
    input wire logic [11:0] portPinOe,
    input wire logic [11:0] pullLowEn,
    input wire logic [11:0] keyLineOe,
    input wire logic        scanInterval,
    input wire logic        haltReleaseByCycle,
    input wire logic        buzzerOut,
    input wire logic        buzzerOutInverted
);
    // Code 1F stands for no strobe
    wire logic [4:0] c = cmdValid ? 5'(cmd) : 5'h1F;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property p_table;
        c == CMD_LATCH_TABLE |=> latchWrite && latchData == $past(tableData);
    endproperty
    a_table: assert property (p_table) else $error("table load");
    property p_direct;
        c == CMD_LATCH_DIRECT |=> latchAddr == $past(cmdLatch)
            && latchData[7:4] == $past(accumulator);
    endproperty
    a_direct: assert property (p_direct) else $error("direct load");
    property p_index;
        c == CMD_INDEX_HIGH_LOAD |=> indexPointer[3:0] == $past(indexPointer[3:0]);
    endproperty
    a_index: assert property (p_index) else $error("index low");
    property p_pcfg;
        c == CMD_PORT_B_CONFIG |-> ##2 portPinOe[7:4] == $past(cmdOperand[3:0], 2)
            && pullLowEn[7:4] == (~portPinOe[7:4] & {4{$past(cmdOperand[4], 2)}});
    endproperty
    a_pcfg: assert property (p_pcfg) else $error("port config");
    property p_halt;
        c == CMD_KEY_SCAN_SETUP |=> haltReleaseByCycle == $past(cmdOperand[6]);
    endproperty
    a_halt: assert property (p_halt) else $error("halt source");
    property p_idle;
        $past(!scanInterval) && !$past(sys_rst) |-> keyLineOe == 12'hFFF;
    endproperty
    a_idle: assert property (p_idle) else $error("idle key lines");
    property p_buzz;
        buzzerOutInverted != buzzerOut;
    endproperty
    a_buzz: assert property (p_buzz) else $error("buzzer pair");
    property p_spec;
        c == CMD_PORT_A_WRITE_SPEC |=> portPinOut[3] && portPinOut[2] == $past(cmdOperand[0]);
    endproperty
    a_spec: assert property (p_spec) else $error("special write");
    c_table: cover property (c == CMD_LATCH_TABLE);
    c_scan: cover property (c == CMD_KEY_SCAN_SETUP ##2 scanInterval);
    c_spec: cover property (c == CMD_PORT_A_WRITE_SPEC);
endmodule
bind io_port_and_scan_control io_port_monitor mon_u (.*);

// File: pin_model.sv
// External pins of the three ports, with an outside driver.
// Assumes pin enables of 1 mean the block drives the pin.
module pin_model (
    input  wire logic        mclk,       // instruction clock
    input  wire logic [11:0] portPinOut, // block drive value
    input  wire logic [11:0] portPinOe,  // block drives pin
    input  wire logic [11:0] pullLowEn,  // pull-low on
    input  wire logic [11:0] extEn,      // outside device drives
    input  wire logic [11:0] extVal,     // outside level
    output logic      [11:0] portPinIn   // resolved level
);
    // Floating pins never settle to a usable level
    logic flt = 1'b0;
    always @(posedge mclk)
        flt <= ~flt;
    always_comb
        for (int i = 0; i < 12; i++)
            portPinIn[i] = portPinOe[i] ? portPinOut[i] : extEn[i] ? extVal[i]
                : pullLowEn[i] ? 1'b0 : flt;
endmodule

// File: tb_top.sv
// Self-checking bench for the I/O block with a pin model.
// Assumes package, interface and design files compile first.
module tb_top
    import io_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, sys_rst = 1'b1, cmdValid = 1'b0, cmdIndexed = 1'b0;
    logic        scanInterval = 1'b0, displayActiveLow = 1'b0, toneGeneratorOutput = 1'b0;
    cmd_t        cmd = CMD_MEM_READ;
    logic [6:0]  cmdAddr = 7'h00;
    logic [3:0]  cmdReg = 4'h0;
    logic [4:0]  cmdLatch = 5'h00;
    logic [8:0]  cmdOperand = 9'h000;
    logic [7:0]  tableData = 8'h00;
    logic [11:0] segmentDrive = 12'h000, extEn = 12'h000, extVal = 12'h000, portPinIn;
    logic [7:0]  indexPointer, latchData, x;
    logic [4:0]  latchAddr;
    logic [3:0]  accumulator, memReadData, lowLevelHoldEn, v, d, h;
    logic [11:0] portPinOut, portPinOe, pullLowEn, keyLineOut, keyLineOe, m;
    logic        latchWrite, haltReleaseByCycle, buzzerOut, buzzerOutInverted, elPumpPin;
    int          n_mismatch = 0, n_compared = 0;
    always #2 mclk = ~mclk;
    io_port_and_scan_control #(.PULSE_LEN(2)) dut_u (.*);
    pin_model pins_u (.*);
    function automatic logic [11:0] seg(logic [3:0] n);
        logic [7:0] t [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D, 8'h07,
                               8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
        return 12'(t[n]);
    endfunction
    function automatic logic [11:0] smask(logic [7:0] s);
        if (!s[7])
            return s[5] ? 12'h000 : s[4] ? 12'hFFF : (s[3:0] < 12) ? 12'h001 << s[3:0] : 12'h000;
        if (!s[5])
            return s[3] ? 12'hF00 : 12'h0FF;
        if (!s[4])
            return (s[3:2] == 2'h3) ? 12'h000 : 12'h00F << (4 * s[3:2]);
        return (s[3:1] > 3'h5) ? 12'h000 : 12'h003 << (2 * s[3:1]);
    endfunction
    task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic issue(cmd_t k, logic [8:0] op = 9'h000, logic [6:0] a = 7'h00);
        wt(1);
        cmdValid = 1'b1;
        cmd = k;
        cmdOperand = op;
        cmdAddr = a;
        wt(1);
        cmdValid = 1'b0;
    endtask
    task automatic results;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(69));
        wt(6);
        sys_rst = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            v = 4'(i);
            cmdReg = 4'($urandom);
            cmdLatch = 5'($urandom);
            issue(CMD_MEM_WRITE, 9'(v), {3'h7, cmdReg});
            issue(CMD_LATCH_DECODED);
            chk("decoded", seg(v), 12'(latchData));
            chk("latchAddr", 12'(cmdLatch), 12'(latchAddr));
            issue(CMD_LATCH_DECODED_BLK);
            chk("blank", (v == 4'h0) ? 12'h000 : seg(v), 12'(latchData));
            d = 4'($urandom);
            issue(CMD_ACC_WRITE, 9'(d));
            issue(CMD_LATCH_DIRECT);
            chk("direct", 12'({d, v}), 12'(latchData));
            h = 4'($urandom % 8);
            issue(CMD_MEM_WRITE, 9'(h), 7'h01);
            issue(CMD_INDEX_HIGH_LOAD, 9'h000, 7'h01);
            issue(CMD_INDEX_LOW_LOAD, 9'h000, {3'h7, cmdReg});
            chk("index", 12'({h, v}), 12'(indexPointer));
            tableData = 8'($urandom);
            issue(CMD_LATCH_TABLE);
            chk("table", 12'(tableData), 12'(latchData));
            cmdIndexed = 1'b1;
            issue(CMD_MEM_WRITE, 9'(d));
            issue(CMD_LATCH_DECODED);
            chk("indexed", seg(d), 12'(latchData));
            cmdIndexed = 1'b0;
        end
        for (int i = 0; i < 6; i++)
        begin
            x = {3'h0, i[0], 4'($urandom)};
            d = 4'($urandom);
            extVal = 12'($urandom);
            extEn = x[4] ? 12'h000 : 12'hFFF;
            issue(cmd_t'(CMD_PORT_A_CONFIG + i / 2), 9'(x));
            issue(CMD_MEM_WRITE, 9'(d), 7'h10);
            issue(cmd_t'(CMD_PORT_A_WRITE + i / 2), 9'h000, 7'h10);
            chk("portOut", 12'(d), 12'(portPinOut[4 * (i / 2) +: 4]));
            chk("pull", 12'(~x[3:0] & {4{x[4]}}), 12'(pullLowEn[4 * (i / 2) +: 4]));
            if (i > 3)
                chk("hold", 12'(~x[3:0] & {4{~x[4]}}), 12'(lowLevelHoldEn));
            repeat (6) @(posedge mclk);
            issue(cmd_t'(CMD_PORT_A_READ + i / 2), 9'h000, 7'h11);
            v = extVal[4 * (i / 2) +: 4] & {4{~x[4]}};
            m = 12'((x[3:0] & d) | (~x[3:0] & v));
            chk("readAcc", m, 12'(accumulator));
            issue(CMD_MEM_READ, 9'h000, 7'h11);
            chk("readMem", m, 12'(memReadData));
        end
        for (int i = 0; i < 2; i++)
        begin
            d = 4'($urandom);
            issue(CMD_MEM_WRITE, 9'(d), 7'h03);
            issue(CMD_PORT_A_WRITE_SPEC, 9'(i), 7'h03);
            chk("special", 12'({1'b1, i[0], d[1:0]}), 12'(portPinOut[3:0]));
            wt(2);
            chk("pulseEnd", 12'h000, 12'(portPinOut[3]));
        end
        scanInterval = 1'b1;
        for (int i = 0; i < 48; i++)
        begin
            x = (i < 16) ? 8'(i) : 8'((i < 18) ? i * 16 - 240 : $urandom);
            displayActiveLow = 1'($urandom);
            segmentDrive = 12'($urandom);
            issue(CMD_KEY_SCAN_SETUP, 9'(x));
            wt(2);
            m = smask(x);
            chk("scanOe", m, keyLineOe);
            chk("scanOut", m & {12{~displayActiveLow}}, m & keyLineOut);
            chk("halt", 12'(x[6]), 12'(haltReleaseByCycle));
        end
        scanInterval = 1'b0;
        issue(CMD_BUZZER_SETUP, 9'h100);
        issue(CMD_EL_DRIVER_SETUP, 9'({DUTY_FULL, 4'h0}));
        wt(2);
        chk("idleOut", segmentDrive, keyLineOut);
        chk("buzzer", 12'h001, 12'(buzzerOut));
        chk("pump", 12'h001, 12'(elPumpPin));
        results();
    end
endmodule
